/* File: inc/uspkg.sv */
// uspkg: register map, field positions and reset values of the
// synchronous serial channel; registers are 8 bits wide, those at offsets 4 to 6 only 6
// assumes a plain one-cycle register port and a single core clock
`default_nettype none
package uspkg;
  localparam int         AW              = 4;
  localparam logic [3:0] OFS_INT_CTL     = 4'h0;
  localparam logic [3:0] OFS_FLAGS_ONE   = 4'h1;
  localparam logic [3:0] OFS_EN_ONE      = 4'h2;
  localparam logic [3:0] OFS_PRIO_ONE    = 4'h3;
  localparam logic [3:0] OFS_FLAGS_THREE = 4'h4;
  localparam logic [3:0] OFS_EN_THREE    = 4'h5;
  localparam logic [3:0] OFS_PRIO_THREE  = 4'h6;
  localparam logic [3:0] OFS_RX_CTL      = 4'h7;
  localparam logic [3:0] OFS_TX_BUF      = 4'h8;
  localparam logic [3:0] OFS_TX_CTL      = 4'h9;
  localparam logic [3:0] OFS_BAUD        = 4'hA;
  localparam logic [3:0] OFS_RX_BUF      = 4'hB;
  localparam int         B_GLOBAL_IE     = 7;
  localparam int         B_PERIPH_IE     = 6;
  localparam int         B_RX_FULL       = 5;
  localparam int         B_TX_EMPTY      = 4;
  localparam int         B_PORT_EN       = 7;
  localparam int         B_RX_NINE       = 6;
  localparam int         B_SINGLE_RX     = 5;
  localparam int         B_CONT_RX       = 4;
  localparam int         B_ADDR_DET      = 3;
  localparam int         B_CLK_SRC       = 7;
  localparam int         B_TX_NINE       = 6;
  localparam int         B_TX_EN         = 5;
  localparam int         B_SYNC_MODE     = 4;
  localparam int         B_HIGH_SPEED    = 2;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_PRIO_ONE    = 8'h7F;
  localparam logic [5:0] RST_PRIO_THREE  = 6'h3F;
  localparam logic [3:0] WORD_BITS       = 4'h8;
  localparam logic [3:0] NINE_BITS       = 4'h9;
endpackage : uspkg
`default_nettype wire

/* File: rtl/usart_sync.sv */
// usart_sync: synchronous half-duplex serial channel, master or slave
// assumes one 10 MHz core clock; two-way pins split in/out/enable
`timescale 1ns/1ps
`default_nettype none
module usart_sync #(
  parameter bit CHANNEL_TWO = 1'b0
) (
  input  wire logic                 core_clk_in,
  input  wire logic                 nrst_in,
  input  wire logic [uspkg::AW-1:0] addr_in,
  input  wire logic [7:0]           wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [7:0]           rdata_out,
  input  wire logic                 sleep_in,
  input  wire logic                 ck_in,
  output logic                      ck_out,
  output logic                      ck_oe_out,
  input  wire logic                 dt_in,
  output logic                      dt_out,
  output logic                      dt_oe_out,
  output logic                      irq_out
);

  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} shift_st_e;

  logic [7:0] int_ctl_q;
  logic [7:0] flags_one_q;
  logic [7:0] enables_one_q;
  logic [7:0] prio_one_q;
  logic [5:0] flags_three_q;
  logic [5:0] enables_three_q;
  logic [5:0] prio_three_q;
  logic       port_en_q;
  logic       rx_nine_q;
  logic       single_rx_q;
  logic       cont_rx_q;
  logic       addr_det_q;
  logic       overrun_q;
  logic       rx_ninth_q;
  logic       clk_src_q;
  logic       tx_nine_q;
  logic       tx_en_q;
  logic       sync_mode_q;
  logic       high_speed_q;
  logic       tx_ninth_q;
  logic [7:0] txbuf_q;
  logic [7:0] rxbuf_q;
  logic [7:0] baud_q;
  logic [7:0] baud_cnt_q;
  logic [7:0] rdata_q;
  logic       txbuf_full_q;
  logic       tx_empty_q;
  logic       rx_full_q;
  logic       ck_q;
  logic       irq_q;
  logic [2:0] ck_s_q;
  logic [2:0] dt_s_q;
  logic       ck_f_q;
  logic       dt_f_q;
  shift_st_e  st_q;
  logic [3:0] bit_cnt_q;
  logic [8:0] tsr_q;
  logic [8:0] rsr_q;

  logic       wr_tx;
  logic       wr_rx_ctl;
  logic       rd_rxbuf;
  logic       en_sync;
  logic       master;
  logic       tick;
  logic       slv_fall;
  logic       fall;
  logic       last_fall;
  logic       tx_go;
  logic       rx_on;
  logic       rx_want;
  logic       rx_done;
  logic       rx_keep;
  logic       tx_ie;
  logic       rx_ie;
  logic [8:0] rx_shift;

  function automatic logic [7:0] with_flags(input logic [7:0] base,
                                            input logic       rxf,
                                            input logic       txf);
    with_flags = base;
    with_flags[uspkg::B_RX_FULL] = rxf;
    with_flags[uspkg::B_TX_EMPTY] = txf;
  endfunction : with_flags

  function automatic logic pick_en(input logic [7:0] one,
                                   input logic [5:0] three,
                                   input int         pos);
    pick_en = CHANNEL_TWO ? three[pos] : one[pos];
  endfunction : pick_en

  assign wr_tx     = wr_in && addr_in == uspkg::OFS_TX_BUF;
  assign wr_rx_ctl = wr_in && addr_in == uspkg::OFS_RX_CTL;
  assign rd_rxbuf  = rd_in && addr_in == uspkg::OFS_RX_BUF;
  assign en_sync   = port_en_q && sync_mode_q;
  assign master    = en_sync && clk_src_q;
  assign tx_ie     = pick_en(enables_one_q, enables_three_q,
                             uspkg::B_TX_EMPTY);
  assign rx_ie     = pick_en(enables_one_q, enables_three_q,
                             uspkg::B_RX_FULL);
  // sleep halts only the internal clock; slave edges keep coming
  assign tick      = master && st_q != ST_IDLE && !sleep_in &&
                     baud_cnt_q == baud_q;
  assign slv_fall  = ck_s_q[2] == ck_s_q[1] && !ck_s_q[1] && ck_f_q;
  assign fall      = master ? (tick && ck_q) : slv_fall;
  assign last_fall = fall && bit_cnt_q == 4'h1;
  assign tx_go     = en_sync && tx_en_q && txbuf_full_q &&
                     (st_q == ST_IDLE ||
                      (st_q == ST_TX && last_fall));
  assign rx_on     = single_rx_q || cont_rx_q;
  // a waiting transmit word wins over reception
  assign rx_want   = en_sync && rx_on && !overrun_q &&
                     !(tx_en_q && txbuf_full_q);
  assign rx_done   = st_q == ST_RX && last_fall && rx_on && !overrun_q;
  assign rx_keep   = rx_done && !(rx_full_q && !rd_rxbuf);
  assign rx_shift  = {dt_f_q, rsr_q[8:1]};

  // pin sampling: three stages, a change counts once two agree
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ck_s_q <= 3'h0;
      dt_s_q <= 3'h0;
      ck_f_q <= 1'b0;
      dt_f_q <= 1'b0;
    end else begin
      ck_s_q <= {ck_s_q[1:0], ck_in};
      dt_s_q <= {dt_s_q[1:0], dt_in};
      if (ck_s_q[2] == ck_s_q[1]) begin
        ck_f_q <= ck_s_q[1];
      end
      if (dt_s_q[2] == dt_s_q[1]) begin
        dt_f_q <= dt_s_q[1];
      end
    end
  end

  // master shift clock: half period of divisor plus one cycles
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      baud_cnt_q <= 8'h00;
      ck_q       <= 1'b0;
    end else if (!master || st_q == ST_IDLE) begin
      baud_cnt_q <= 8'h00;
      ck_q       <= 1'b0;
    end else if (tick) begin
      baud_cnt_q <= 8'h00;
      ck_q       <= ~ck_q;
    end else if (!sleep_in) begin
      baud_cnt_q <= baud_cnt_q + 8'h01;
    end
  end

  // shift engine: one word at a time, either direction
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q      <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      tsr_q     <= 9'h000;
      rsr_q     <= 9'h000;
    end else if (!en_sync) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (tx_go) begin
            st_q      <= ST_TX;
            tsr_q     <= {tx_ninth_q, txbuf_q};
            bit_cnt_q <= tx_nine_q ? uspkg::NINE_BITS : uspkg::WORD_BITS;
          end else if (rx_want) begin
            st_q      <= ST_RX;
            bit_cnt_q <= rx_nine_q ? uspkg::NINE_BITS : uspkg::WORD_BITS;
          end
        end
        ST_TX: begin
          if (tx_go) begin
            tsr_q     <= {tx_ninth_q, txbuf_q};
            bit_cnt_q <= tx_nine_q ? uspkg::NINE_BITS : uspkg::WORD_BITS;
          end else if (last_fall) begin
            st_q <= ST_IDLE;
          end else if (fall) begin
            tsr_q     <= {1'b0, tsr_q[8:1]};
            bit_cnt_q <= bit_cnt_q - 4'h1;
          end
        end
        ST_RX: begin
          if (!rx_on || overrun_q) begin
            st_q <= ST_IDLE;
          end else if (fall) begin
            rsr_q <= rx_shift;
            if (bit_cnt_q != 4'h1) begin
              bit_cnt_q <= bit_cnt_q - 4'h1;
            end else if (cont_rx_q) begin
              // continuous wins when both enables are set
              bit_cnt_q <= rx_nine_q ? uspkg::NINE_BITS
                                     : uspkg::WORD_BITS;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // transmit buffer and its empty flag
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      txbuf_q      <= uspkg::RST_ZERO;
      txbuf_full_q <= 1'b0;
      tx_empty_q   <= 1'b0;
    end else begin
      if (wr_tx) begin
        txbuf_q      <= wdata_in;
        txbuf_full_q <= 1'b1;
      end else if (tx_go) begin
        txbuf_full_q <= 1'b0;
      end
      // one cycle behind the buffer, so a write shows a cycle late
      tx_empty_q <= tx_en_q && !txbuf_full_q;
    end
  end

  // receive buffer, full flag and overrun
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rxbuf_q    <= uspkg::RST_ZERO;
      rx_ninth_q <= 1'b0;
      rx_full_q  <= 1'b0;
      overrun_q  <= 1'b0;
    end else begin
      if (rx_keep) begin
        rxbuf_q    <= rx_nine_q ? rx_shift[7:0] : rx_shift[8:1];
        rx_ninth_q <= rx_nine_q && rx_shift[8];
        rx_full_q  <= 1'b1;
      end else if (rd_rxbuf) begin
        rx_full_q <= 1'b0;
      end
      // a word landing on a full buffer is dropped, error set wins
      if (rx_done && !rx_keep) begin
        overrun_q <= 1'b1;
      end else if (wr_rx_ctl && !wdata_in[uspkg::B_CONT_RX]) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // single-word enable clears itself once its word is in
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      single_rx_q <= 1'b0;
    end else if (wr_rx_ctl) begin
      single_rx_q <= wdata_in[uspkg::B_SINGLE_RX];
    end else if (rx_done && !cont_rx_q) begin
      single_rx_q <= 1'b0;
    end
  end

  // software-written control and plain storage registers
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_ctl_q       <= uspkg::RST_ZERO;
      flags_one_q     <= uspkg::RST_ZERO;
      enables_one_q   <= uspkg::RST_ZERO;
      prio_one_q      <= uspkg::RST_PRIO_ONE;
      flags_three_q   <= 6'h00;
      enables_three_q <= 6'h00;
      prio_three_q    <= uspkg::RST_PRIO_THREE;
      port_en_q       <= 1'b0;
      rx_nine_q       <= 1'b0;
      cont_rx_q       <= 1'b0;
      addr_det_q      <= 1'b0;
      clk_src_q       <= 1'b0;
      tx_nine_q       <= 1'b0;
      tx_en_q         <= 1'b0;
      sync_mode_q     <= 1'b0;
      high_speed_q    <= 1'b0;
      tx_ninth_q      <= 1'b0;
      baud_q          <= uspkg::RST_ZERO;
    end else if (wr_in) begin
      case (addr_in)
        uspkg::OFS_INT_CTL:     int_ctl_q <= wdata_in;
        uspkg::OFS_FLAGS_ONE:   flags_one_q <= wdata_in;
        uspkg::OFS_EN_ONE:      enables_one_q <= wdata_in;
        uspkg::OFS_PRIO_ONE:    prio_one_q <= wdata_in;
        uspkg::OFS_FLAGS_THREE: flags_three_q <= wdata_in[5:0];
        uspkg::OFS_EN_THREE:    enables_three_q <= wdata_in[5:0];
        uspkg::OFS_PRIO_THREE:  prio_three_q <= wdata_in[5:0];
        uspkg::OFS_RX_CTL: begin
          port_en_q  <= wdata_in[uspkg::B_PORT_EN];
          rx_nine_q  <= wdata_in[uspkg::B_RX_NINE];
          cont_rx_q  <= wdata_in[uspkg::B_CONT_RX];
          addr_det_q <= wdata_in[uspkg::B_ADDR_DET];
        end
        uspkg::OFS_TX_CTL: begin
          clk_src_q    <= wdata_in[uspkg::B_CLK_SRC];
          tx_nine_q    <= wdata_in[uspkg::B_TX_NINE];
          tx_en_q      <= wdata_in[uspkg::B_TX_EN];
          sync_mode_q  <= wdata_in[uspkg::B_SYNC_MODE];
          high_speed_q <= wdata_in[uspkg::B_HIGH_SPEED];
          tx_ninth_q   <= wdata_in[0];
        end
        uspkg::OFS_BAUD:        baud_q <= wdata_in;
        default: begin
        end
      endcase
    end
  end

  // read port: data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= uspkg::RST_ZERO;
    end else if (!rd_in) begin
      rdata_q <= uspkg::RST_ZERO;
    end else begin
      case (addr_in)
        uspkg::OFS_INT_CTL:     rdata_q <= int_ctl_q;
        uspkg::OFS_FLAGS_ONE:
          rdata_q <= CHANNEL_TWO ? flags_one_q
                     : with_flags(flags_one_q, rx_full_q,
                                  tx_empty_q);
        uspkg::OFS_EN_ONE:      rdata_q <= enables_one_q;
        uspkg::OFS_PRIO_ONE:    rdata_q <= prio_one_q;
        uspkg::OFS_FLAGS_THREE:
          rdata_q <= !CHANNEL_TWO ? {2'h0, flags_three_q}
                     : with_flags({2'h0, flags_three_q}, rx_full_q,
                                  tx_empty_q);
        uspkg::OFS_EN_THREE:    rdata_q <= {2'h0, enables_three_q};
        uspkg::OFS_PRIO_THREE:  rdata_q <= {2'h0, prio_three_q};
        uspkg::OFS_RX_CTL:
          rdata_q <= {port_en_q, rx_nine_q, single_rx_q, cont_rx_q,
                      addr_det_q, 1'b0, overrun_q, rx_ninth_q};
        uspkg::OFS_TX_BUF:      rdata_q <= txbuf_q;
        uspkg::OFS_TX_CTL:
          rdata_q <= {clk_src_q, tx_nine_q, tx_en_q, sync_mode_q, 1'b0,
                      high_speed_q, st_q != ST_TX, tx_ninth_q};
        uspkg::OFS_BAUD:        rdata_q <= baud_q;
        uspkg::OFS_RX_BUF:      rdata_q <= rxbuf_q;
        default:                rdata_q <= uspkg::RST_ZERO;
      endcase
    end
  end

  // request line; the shifter-empty bit feeds nothing here
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= int_ctl_q[uspkg::B_GLOBAL_IE] &&
               int_ctl_q[uspkg::B_PERIPH_IE] &&
               ((tx_empty_q && tx_ie) ||
                (rx_full_q && rx_ie));
    end
  end

  assign rdata_out = rdata_q;
  assign ck_out    = ck_q;
  assign ck_oe_out = master;
  assign dt_out    = tsr_q[0];
  assign dt_oe_out = en_sync && st_q == ST_TX;
  assign irq_out   = irq_q;

  default clocking dc @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_buf_load;
    tx_go && !wr_in;
  endsequence

  sequence s_buf_write;
    wr_tx && tx_en_q && tx_empty_q;
  endsequence

  a_no_midword_load:
    assert property (st_q == ST_TX && bit_cnt_q > 4'h1 &&
                     txbuf_full_q |=> txbuf_full_q)
    else $error("buffer drained before last bit left");

  a_move_one_cycle:
    assert property (s_buf_load |=> !txbuf_full_q ##1 tx_empty_q)
    else $error("buffer move or empty flag late");

  a_flag_no_sw_clear:
    assert property (tx_empty_q && !txbuf_full_q && wr_in && !wr_tx &&
                     tx_en_q && addr_in != uspkg::OFS_TX_CTL |=> tx_empty_q)
    else $error("software cleared the empty flag");

  a_flag_two_cycles:
    assert property (s_buf_write |=> tx_empty_q ##1 !tx_empty_q)
    else $error("empty flag not cleared in second cycle");

  a_shift_empty_rd:
    assert property (rd_in && addr_in == uspkg::OFS_TX_CTL |=>
                     rdata_out[1] == ($past(st_q) != ST_TX))
    else $error("shifter-empty bit wrong");

  a_rx_fall_sample:
    assert property (en_sync && st_q == ST_RX && fall && rx_on &&
                     !overrun_q |=> rsr_q[8] == $past(dt_f_q))
    else $error("receive bit not taken at falling edge");

  a_single_stops:
    assert property (rx_done && !cont_rx_q && !wr_in |=>
                     st_q == ST_IDLE && !single_rx_q)
    else $error("single reception did not stop");

  a_cont_goes_on:
    assert property (rx_done && cont_rx_q && !rx_full_q && en_sync |=>
                     st_q == ST_RX && bit_cnt_q >= uspkg::WORD_BITS)
    else $error("continuous reception stopped");

  a_full_on_done:
    assert property (rx_done |=> rx_full_q)
    else $error("full flag not raised");

  a_cont_clear_err:
    assert property (wr_rx_ctl && !wdata_in[uspkg::B_CONT_RX] &&
                     !rx_done |=> !overrun_q)
    else $error("error not cleared with continuous enable");

  a_slave_no_clock:
    assert property (en_sync && !clk_src_q |-> !ck_oe_out && !tick)
    else $error("slave drives its own clock");

  a_master_toggle:
    assert property (tick |=> ck_out != $past(ck_out))
    else $error("shift clock did not toggle");

  a_half_duplex:
    assert property (st_q == ST_RX |-> !dt_oe_out ##1
                     (st_q != ST_TX || $past(st_q) != ST_RX))
    else $error("transmit overlapped reception");

endmodule : usart_sync
`default_nettype wire

/* File: tb/serial_peer.sv */
// serial_peer: far-side synchronous serial device on clock and data wires
// assumes the bench resolves both wires from every party's enable
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input  wire logic        ck_in,
  input  wire logic        dt_in,
  input  wire logic        dev_oe_in,
  input  wire logic        slave_in,
  input  wire logic        go_in,
  input  wire logic        load_in,
  input  wire logic [31:0] tx_in,
  output logic             ck_out,
  output logic             ck_oe_out,
  output logic             dt_out,
  output logic             dt_oe_out,
  output logic      [8:0]  rx_out,
  output var int           rx_cnt_out
);
  logic [31:0] sh;
  int          n;
  // drives data whenever the device has let go of the wire
  assign dt_oe_out = !dev_oe_in;
  assign dt_out    = sh[0];
  assign ck_oe_out = slave_in;
  initial begin
    ck_out     = 1'b0;
    sh         = '0;
    n          = 0;
    rx_out     = '0;
    rx_cnt_out = 0;
  end
  always @(posedge load_in) sh = tx_in;
  // next bit well after the fall, so either end samples the old one
  always @(negedge ck_in) begin
    #325 sh = {~sh[0], sh[31:1]};
  end
  // device data steady at the rising edge; lsb first, nine bits
  always @(posedge ck_in) if (dev_oe_in) begin
    rx_out = {dt_in, rx_out[8:1]};
    n      = (n == 8) ? 0 : n + 1;
    if (n == 0) rx_cnt_out++;
  end
  // clock only within a frame, stands low between frames
  // offset keeps both wires off the core clock rising edges
  always @(posedge go_in) begin
    #50;
    repeat (8) begin
      #400 ck_out = 1'b1;
      #400 ck_out = 1'b0;
    end
  end
endmodule : serial_peer
`default_nettype wire

/* File: tb/test_usart_sync.sv */
// test_usart_sync: self-checking bench of the synchronous serial channel
// assumes uspkg and the serial_peer model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_usart_sync;
  logic        clk, nrst, wr, rd, sleep, load, go, slave;
  logic        flip = 1'b0;
  logic        ck, ck_oe, dt, dt_oe, irq, p_ck, p_ck_oe, p_dt, p_dt_oe;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, v, w0, w1;
  logic [8:0]  rxw;
  logic [31:0] txw;
  int          rxn, c0;
  int          gaps = 0, ckr = 0, mismatches = 0, n_checks = 0;
  // no pull on the wires: a released wire toggles
  wire logic   ck_line = ck_oe ? ck : (p_ck_oe ? p_ck : flip);
  wire logic   dt_line = dt_oe ? dt : (p_dt_oe ? p_dt : flip);

  usart_sync uut (
    .core_clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sleep_in(sleep),
    .ck_in(ck_line), .ck_out(ck), .ck_oe_out(ck_oe), .dt_in(dt_line),
    .dt_out(dt), .dt_oe_out(dt_oe), .irq_out(irq)
  );
  serial_peer peer (
    .ck_in(ck_line), .dt_in(dt_line), .dev_oe_in(dt_oe), .slave_in(slave),
    .go_in(go), .load_in(load), .tx_in(txw), .ck_out(p_ck),
    .ck_oe_out(p_ck_oe), .dt_out(p_dt), .dt_oe_out(p_dt_oe),
    .rx_out(rxw), .rx_cnt_out(rxn)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) flip <= ~flip;
  always @(posedge clk) if (rxn == 1 && dt_oe !== 1'b1) gaps++;
  always @(posedge ck) ckr++;

  function automatic logic [8:0] frame(input logic [7:0] d, input logic b);
    return {b, d};
  endfunction : frame
  function automatic logic [7:0] exp_rst(input logic [3:0] a);
    case (a)
      uspkg::OFS_PRIO_ONE:   return uspkg::RST_PRIO_ONE;
      uspkg::OFS_PRIO_THREE: return {2'b00, uspkg::RST_PRIO_THREE};
      uspkg::OFS_TX_CTL:     return 8'h02;
      default:               return 8'h00;
    endcase
  endfunction : exp_rst

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // all bus tasks start right after a rising edge
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    // wr still reads high right after a write: let one edge pass
    if (wr) @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [3:0] a);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    // data stand until the next edge; taken there, before it updates
    @(posedge clk);
    v = rdata;
  endtask : rdr
  task automatic ld;
    txw  <= $urandom;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask : ld
  task automatic wait_n(input int n);
    for (int i = 0; i < 3000 && rxn < n; i++) @(posedge clk);
  endtask : wait_n
  task automatic wait_rx;
    v = '0;
    for (int i = 0; i < 300 && v[uspkg::B_RX_FULL] !== 1'b1; i++)
      rdr(uspkg::OFS_FLAGS_ONE);
    chk(9'(v[uspkg::B_RX_FULL]), 9'h001);
  endtask : wait_rx
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial begin
    #2000000;
    mismatches++;
    test_done;
  end

  initial begin
    {nrst, wr, rd, sleep, load, go, slave} = '0;
    {addr, wdata, txw} = '0;
    void'($urandom(12636));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 13; i++) begin
      rdr(4'(i));
      if (i != 7) chk(9'(v), 9'(exp_rst(4'(i))));
    end
    $display("reset values done");
    wrr(uspkg::OFS_BAUD, 8'h04);
    wrr(uspkg::OFS_RX_CTL, 8'h80);
    wrr(uspkg::OFS_TX_CTL, 8'hF1);
    wrr(uspkg::OFS_INT_CTL, 8'hC0);
    wrr(uspkg::OFS_EN_ONE, 8'h10);
    repeat (3) @(posedge clk);
    chk(9'(ck_oe), 9'h001);
    chk(9'(irq), 9'h001);
    w0 = 8'($urandom);
    w1 = 8'($urandom);
    wrr(uspkg::OFS_TX_BUF, w0);
    repeat (6) @(posedge clk);
    wrr(uspkg::OFS_TX_BUF, w1);
    rdr(uspkg::OFS_FLAGS_ONE);
    chk(9'(v[uspkg::B_TX_EMPTY]), 9'h001);
    rdr(uspkg::OFS_FLAGS_ONE);
    chk(9'(v[uspkg::B_TX_EMPTY]), 9'h000);
    rdr(uspkg::OFS_TX_CTL);
    chk(9'(v), 9'h0F1);
    chk(9'(irq), 9'h000);
    wait_n(1);
    chk(rxw, frame(w0, 1'b1));
    wait_n(2);
    chk(rxw, frame(w1, 1'b1));
    chk(9'(gaps), 9'h000);
    repeat (20) @(posedge clk);
    rdr(uspkg::OFS_TX_CTL);
    chk(9'(v), 9'h0F3);
    chk(9'(irq), 9'h001);
    wrr(uspkg::OFS_FLAGS_ONE, 8'h00);
    rdr(uspkg::OFS_FLAGS_ONE);
    chk(9'(v[uspkg::B_TX_EMPTY]), 9'h001);
    wrr(uspkg::OFS_EN_ONE, 8'h00);
    rdr(uspkg::OFS_FLAGS_ONE);
    chk(9'(irq), 9'h000);
    $display("master transmit done");
    wrr(uspkg::OFS_TX_CTL, 8'h90);
    wrr(uspkg::OFS_EN_ONE, 8'h20);
    ld;
    wrr(uspkg::OFS_RX_CTL, 8'hA0);
    wait_rx;
    chk(9'(irq), 9'h001);
    rdr(uspkg::OFS_RX_CTL);
    chk(9'(v), 9'h080);
    rdr(uspkg::OFS_RX_BUF);
    chk(9'(v), 9'(txw[7:0]));
    c0 = ckr;
    repeat (100) @(posedge clk);
    chk(9'(ckr - c0), 9'h000);
    $display("single receive done");
    ld;
    wrr(uspkg::OFS_RX_CTL, 8'hB0);
    for (int k = 0; k < 2; k++) begin
      wait_rx;
      rdr(uspkg::OFS_RX_BUF);
      chk(9'(v), 9'(txw[8*k +: 8]));
    end
    wait_rx;
    v = '0;
    for (int i = 0; i < 200 && v[1] !== 1'b1; i++)
      rdr(uspkg::OFS_RX_CTL);
    chk(9'(v[1]), 9'h001);
    wrr(uspkg::OFS_RX_CTL, 8'h80);
    rdr(uspkg::OFS_RX_CTL);
    chk(9'(v), 9'h080);
    $display("continuous receive done");
    slave <= 1'b1;
    sleep <= 1'b1;
    ld;
    wrr(uspkg::OFS_TX_CTL, 8'h10);
    wrr(uspkg::OFS_RX_CTL, 8'h90);
    rdr(uspkg::OFS_RX_BUF);
    chk(9'(ck_oe), 9'h000);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_rx;
    rdr(uspkg::OFS_RX_BUF);
    chk(9'(v), 9'(txw[7:0]));
    $display("slave receive done");
    test_done;
  end
endmodule : test_usart_sync
`default_nettype wire
